// ===== hdl/cpu_ctl_pkg.sv
package cpu_ctl_pkg;
  // program counter and condition codes after reset
  localparam logic [15:0] PC_RESET      = 16'h0000;
  localparam logic [7:0]  CCR_RESET     = 8'h80;
  // condition code bit positions
  localparam int          CCR_C         = 0;
  localparam int          CCR_V         = 1;
  localparam int          CCR_Z         = 2;
  localparam int          CCR_N         = 3;
  // instruction lengths in bytes
  localparam logic [15:0] PC_STEP       = 16'h0002;
  localparam logic [15:0] PC_STEP_LONG  = 16'h0004;
  // pointer steps for byte and word operands
  localparam logic [15:0] BYTE_STEP     = 16'h0001;
  localparam logic [15:0] WORD_STEP     = 16'h0002;
  // upper bytes of short absolute and memory indirect addresses
  localparam logic [7:0]  ABS8_PAGE     = 8'hff;
  localparam logic [7:0]  IND_PAGE      = 8'h00;
  // position of the bit number inside its instruction byte
  localparam int          BITNO_LSB     = 4;

  // branch conditions
  typedef enum logic [3:0] {
    branch_always, branch_never, branch_if_higher, branch_if_lower_or_same,
    branch_if_carry_clear, branch_if_carry_set, branch_if_not_equal, branch_if_equal,
    branch_if_overflow_clear, branch_if_overflow_set, branch_if_plus, branch_if_minus,
    branch_if_greater_or_equal, branch_if_less_than, branch_if_greater,
    branch_if_less_or_equal
  } cond_e;

  // instruction classes handled here; seventeen of them need a fifth bit
  typedef enum logic [4:0] {
    no_operation, cond_branch, unconditional_jump, relative_subroutine_call,
    absolute_subroutine_call, subroutine_return, exception_return, power_down,
    load_condition_codes, store_condition_codes, and_condition_codes,
    or_condition_codes, xor_condition_codes, block_copy, address_gen,
    add_small_constant, subtract_small_constant
  } op_e;

  // addressing modes
  typedef enum logic [3:0] {
    am_reg, am_ind, am_disp, am_postinc, am_predec, am_abs8, am_abs16,
    am_imm8, am_imm16, am_pcrel, am_memind
  } mode_e;

  // one decoded instruction
  typedef struct packed {
    op_e         op;
    cond_e       cond;
    mode_e       mode;
    logic        word;
    logic        len4;
    logic        bit_hi;
    logic [15:0] reg_val;
    logic [15:0] sp;
    logic [7:0]  byte2;
    logic [15:0] ext;
  } insn_s;

  // results handed back to the register file
  typedef struct packed {
    logic        reg_wr;
    logic [15:0] reg_val;
    logic [15:0] ea;
    logic [15:0] operand;
    logic [2:0]  bit_num;
    logic        sp_wr;
    logic [15:0] sp;
  } result_s;

  // block copy count and pointers
  typedef struct packed {
    logic [7:0]  count;
    logic [15:0] src;
    logic [15:0] dst;
  } block_s;
endpackage

// ===== hdl/cpu_branch_sysctl.sv
`timescale 1ns/1ps
module cpu_branch_sysctl (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic                  insn_valid,
  output logic                       insn_ready,
  input  wire cpu_ctl_pkg::insn_s    insn,
  input  wire cpu_ctl_pkg::block_s   blk_in,
  input  wire logic                  wake,
  output cpu_ctl_pkg::result_s       res,
  output cpu_ctl_pkg::block_s        blk,
  output logic [15:0]                pc,
  output logic [7:0]                 condition_code_register,
  output logic                       done,
  output logic                       sleeping,
  output logic                       mem_req,
  output logic                       mem_we,
  output logic                       mem_word,
  output logic [15:0]                mem_addr,
  output logic [15:0]                mem_wdata,
  input  wire logic [15:0]           mem_rdata,
  input  wire logic                  mem_ack
);
  import cpu_ctl_pkg::*;

  // sequencer states; most instructions finish in idle in one cycle
  typedef enum logic [2:0] {
    st_idle, st_ind, st_push, st_pop_ccr, st_pop_pc, st_blk_rd, st_blk_wr, st_sleep
  } state_e;

  state_e      state, next_state;          // sequencer state
  op_e         op_q, next_op_q;            // op held across memory steps
  logic [15:0] target, next_target;        // pending pc
  logic [15:0] next_pc, next_maddr, next_wdata;
  logic [7:0]  next_ccr;
  logic        next_done;
  result_s     next_res;
  block_s      next_blk;
  logic [15:0] seq, tgt, step;             // fall-through pc, target, size step

  // condition evaluation from the flags
  function automatic logic cond_true(input cond_e c, input logic [7:0] f);
    logic nv;
    nv = f[CCR_N] ^ f[CCR_V];
    unique case (c)
      branch_always:              cond_true = 1'b1;
      branch_never:               cond_true = 1'b0;
      branch_if_higher:           cond_true = !(f[CCR_C] | f[CCR_Z]);
      branch_if_lower_or_same:    cond_true = f[CCR_C] | f[CCR_Z];
      branch_if_carry_clear:      cond_true = !f[CCR_C];
      branch_if_carry_set:        cond_true = f[CCR_C];
      branch_if_not_equal:        cond_true = !f[CCR_Z];
      branch_if_equal:            cond_true = f[CCR_Z];
      branch_if_overflow_clear:   cond_true = !f[CCR_V];
      branch_if_overflow_set:     cond_true = f[CCR_V];
      branch_if_plus:             cond_true = !f[CCR_N];
      branch_if_minus:            cond_true = f[CCR_N];
      branch_if_greater_or_equal: cond_true = !nv;
      branch_if_less_than:        cond_true = nv;
      branch_if_greater:          cond_true = !(f[CCR_Z] | nv);
      branch_if_less_or_equal:    cond_true = f[CCR_Z] | nv;
    endcase
  endfunction

  // odd word addresses and targets drop their low bit
  function automatic logic [15:0] align_w(input logic [15:0] a);
    align_w = {a[15:1], 1'b0};
  endfunction

  // sign extension of a byte displacement
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction

  // handshake: a new instruction only when the sequencer is free
  assign insn_ready = (state == st_idle);
  assign sleeping   = (state == st_sleep);
  assign mem_req    = !(state inside {st_idle, st_sleep});
  assign mem_we     = (state inside {st_push, st_blk_wr});
  // block copy moves bytes, every other access is a word
  assign mem_word   = !(state inside {st_blk_rd, st_blk_wr});

  // next-state and datapath decisions
  always_comb begin
    next_state  = state;
    next_op_q   = op_q;
    next_target = target;
    next_pc     = pc;
    next_ccr    = condition_code_register;
    next_maddr  = mem_addr;
    next_wdata  = mem_wdata;
    next_res    = res;
    next_blk    = blk;
    next_done   = 1'b0;
    next_res.reg_wr = 1'b0;
    next_res.sp_wr  = 1'b0;
    seq  = pc + (insn.len4 ? PC_STEP_LONG : PC_STEP);
    step = insn.word ? WORD_STEP : BYTE_STEP;
    tgt  = (insn.mode == am_pcrel) ? seq + sext8(insn.byte2) :
           (insn.mode == am_ind)   ? insn.reg_val : insn.ext;
    unique case (state)
      st_idle: if (insn_valid) begin
        next_pc   = seq;
        next_done = 1'b1;
        next_op_q = insn.op;
        unique case (insn.op)
          no_operation: ;
          // taken only on a true condition
          cond_branch: if (cond_true(insn.cond, condition_code_register)) next_pc = align_w(tgt);
          unconditional_jump, relative_subroutine_call, absolute_subroutine_call: begin
            next_wdata  = seq;
            next_target = align_w(tgt);
            next_res.sp = insn.sp;
            if (insn.mode == am_memind) begin
              // fetch destination word from low page
              next_state = st_ind;
              next_maddr = {IND_PAGE, insn.byte2};
              next_pc    = pc;
              next_done  = 1'b0;
            end else if (insn.op != unconditional_jump) begin
              next_state = st_push;
              next_maddr = insn.sp - WORD_STEP;
              next_pc    = pc;
              next_done  = 1'b0;
            end else begin
              next_pc = align_w(tgt);
            end
          end
          subroutine_return, exception_return: begin
            next_state  = (insn.op == exception_return) ? st_pop_ccr : st_pop_pc;
            next_maddr  = insn.sp;
            next_pc     = pc;
            next_done   = 1'b0;
          end
          power_down: begin
            next_state = st_sleep;
            next_done  = 1'b0;
          end
          // load flags from register or immediate
          load_condition_codes: next_ccr = (insn.mode == am_imm8) ? insn.byte2 :
                                           insn.reg_val[7:0];
          store_condition_codes: begin
            next_res.reg_val = {8'h00, condition_code_register};
            next_res.reg_wr  = 1'b1;
          end
          and_condition_codes: next_ccr = condition_code_register & insn.byte2;
          or_condition_codes:  next_ccr = condition_code_register | insn.byte2;
          xor_condition_codes: next_ccr = condition_code_register ^ insn.byte2;
          block_copy: begin
            next_blk = blk_in;
            if (blk_in.count != 8'h00) begin
              next_state  = st_blk_rd;
              next_maddr  = blk_in.src;
              next_target = seq;
              next_pc     = pc;
              next_done   = 1'b0;
            end
          end
          address_gen: begin
            next_res.operand = insn.word ? insn.reg_val : {8'h00, insn.reg_val[7:0]};
            next_res.ea      = insn.reg_val;
            // bit number from byte two or byte four
            next_res.bit_num = insn.bit_hi ? insn.ext[BITNO_LSB +: 3] :
                                             insn.byte2[BITNO_LSB +: 3];
            unique case (insn.mode)
              am_reg: next_res.ea = 16'h0000;
              am_ind: next_res.ea = insn.reg_val;
              am_disp: next_res.ea = insn.reg_val + insn.ext;
              am_postinc: begin
                next_res.ea      = insn.reg_val;
                next_res.reg_val = insn.reg_val + step;
                next_res.reg_wr  = 1'b1;
              end
              am_predec: begin
                next_res.ea      = insn.reg_val - step;
                next_res.reg_val = insn.reg_val - step;
                next_res.reg_wr  = 1'b1;
              end
              // short absolute in the top page
              am_abs8:   next_res.ea = {ABS8_PAGE, insn.byte2};
              am_abs16:  next_res.ea = insn.ext;
              am_imm8:   next_res.operand = {8'h00, insn.byte2};
              am_imm16:  next_res.operand = insn.ext;
              am_pcrel:  next_res.ea = tgt;
              am_memind: next_res.ea = {IND_PAGE, insn.byte2};
            endcase
            if (insn.word) next_res.ea = align_w(next_res.ea);
          end
          add_small_constant, subtract_small_constant: begin
            // implied constant of one or two
            next_res.reg_val = (insn.op == add_small_constant) ? insn.reg_val + step :
                                                                 insn.reg_val - step;
            next_res.reg_wr  = 1'b1;
          end
        endcase
      end
      st_ind: if (mem_ack) begin
        next_target = align_w(mem_rdata);
        if (op_q == unconditional_jump) begin
          next_pc    = align_w(mem_rdata);
          next_done  = 1'b1;
          next_state = st_idle;
        end else begin
          next_state = st_push;
          next_maddr = res.sp - WORD_STEP;
        end
      end
      st_push: if (mem_ack) begin
        next_pc        = target;
        next_res.sp    = mem_addr;
        next_res.sp_wr = 1'b1;
        next_done      = 1'b1;
        next_state     = st_idle;
      end
      st_pop_ccr: if (mem_ack) begin
        // flags come back first, in the upper byte
        next_ccr   = mem_rdata[15:8];
        next_maddr = mem_addr + WORD_STEP;
        next_state = st_pop_pc;
      end
      st_pop_pc: if (mem_ack) begin
        next_pc        = align_w(mem_rdata);
        next_res.sp    = mem_addr + WORD_STEP;
        next_res.sp_wr = 1'b1;
        next_done      = 1'b1;
        next_state     = st_idle;
      end
      st_blk_rd: if (mem_ack) begin
        next_wdata = {8'h00, mem_rdata[7:0]};
        next_maddr = blk.dst;
        next_state = st_blk_wr;
      end
      st_blk_wr: if (mem_ack) begin
        next_blk.src   = blk.src + BYTE_STEP;
        next_blk.dst   = blk.dst + BYTE_STEP;
        next_blk.count = blk.count - 8'h01;
        next_maddr     = blk.src + BYTE_STEP;
        next_state     = st_blk_rd;
        if (blk.count == 8'h01) begin
          next_pc    = target;
          next_done  = 1'b1;
          next_state = st_idle;
        end
      end
      // wake-up is a level from the power control; the pc already points past
      st_sleep: if (wake) begin
        next_done  = 1'b1;
        next_state = st_idle;
      end
    endcase
  end

  // registers only; clk_en low freezes every bit of state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= st_idle;
      op_q      <= no_operation;
      target    <= PC_RESET;
      pc        <= PC_RESET;
      condition_code_register       <= CCR_RESET;
      mem_addr  <= 16'h0000;
      mem_wdata <= 16'h0000;
      res       <= '0;
      blk       <= '0;
      done      <= 1'b0;
    end else if (clk_en) begin
      state     <= next_state;
      op_q      <= next_op_q;
      target    <= next_target;
      pc        <= next_pc;
      condition_code_register       <= next_ccr;
      mem_addr  <= next_maddr;
      mem_wdata <= next_wdata;
      res       <= next_res;
      blk       <= next_blk;
      done      <= next_done;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic acc;
  assign acc = insn_valid && insn_ready && clk_en;

  a_branch_taken: assert property (acc && insn.op == cond_branch && cond_true(insn.cond, condition_code_register)
    |=> pc == align_w($past(pc) + PC_STEP + sext8($past(insn.byte2))))
    else $error("taken branch pc wrong");
  a_signed_cond: assert property (acc && insn.op == cond_branch
    && insn.cond == branch_if_less_than && (condition_code_register[CCR_N] == condition_code_register[CCR_V]) && !insn.len4
    |=> pc == $past(pc) + PC_STEP)
    else $error("less-than taken with equal flags");
  a_false_falls: assert property (acc && insn.op == cond_branch && !cond_true(insn.cond, condition_code_register)
    |=> pc == $past(pc) + (($past(insn.len4)) ? PC_STEP_LONG : PC_STEP)
        && condition_code_register == $past(condition_code_register))
    else $error("false branch did not fall through");
  a_nop_only_pc: assert property (acc && insn.op == no_operation && !insn.len4
    |=> pc == $past(pc) + PC_STEP && condition_code_register == $past(condition_code_register) && !res.reg_wr)
    else $error("no-operation changed more than pc");
  a_and_condition_codes_flags: assert property (acc && insn.op == and_condition_codes
    |=> condition_code_register == ($past(condition_code_register) & $past(insn.byte2)))
    else $error("flag and wrong");
  a_blk_zero: assert property (acc && insn.op == block_copy && blk_in.count == 8'h00
    |=> done && state == st_idle ##1 !mem_req)
    else $error("zero count block copy moved data");
  a_postinc_step: assert property (acc && insn.op == address_gen && insn.mode == am_postinc
    |=> res.reg_wr && res.reg_val == $past(insn.reg_val) + ($past(insn.word) ? 16'h2 : 16'h1)
        && res.ea[15:1] == $past(insn.reg_val[15:1]))
    else $error("post-increment wrong");
  a_predec_keep: assert property (acc && insn.op == address_gen && insn.mode == am_predec
    |=> res.reg_val == res.ea || !$past(insn.word) && res.reg_val[15:1] == res.ea[15:1])
    else $error("pre-decrement address differs from kept value");
  a_abs8_page: assert property (acc && insn.op == address_gen && insn.mode == am_abs8
    |=> res.ea[15:8] == ABS8_PAGE)
    else $error("short absolute outside top page");
  a_word_even: assert property (acc && insn.op == address_gen && insn.word
    |=> !res.ea[0])
    else $error("odd word address");
  a_push_before: assert property (state == st_push && mem_ack && clk_en
    |=> pc == $past(target) && res.sp_wr && res.sp == $past(mem_addr))
    else $error("call did not enter target");

  c_branch_taken: cover property (acc && insn.op == cond_branch && cond_true(insn.cond, condition_code_register));
  c_block_done:   cover property (state == st_blk_wr ##1 done);
  c_return:       cover property (state == st_pop_pc ##1 done);
  c_sleep_wake:   cover property (sleeping ##1 !sleeping);
endmodule

// ===== verif/mem_model.sv
`timescale 1ns/1ps
// behavioural program and data memory on the far side of the memory port
module mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_word,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [3:0]  delay,
  output logic [15:0]      mem_rdata,
  output logic             mem_ack
);
  logic [7:0]  m [0:65535];  // byte array, upper byte of a word at the even address
  logic [3:0]  cnt = 4'h0;   // wait states served so far
  logic [15:0] last = 16'h0; // last word handed out
  // ack once the programmed wait has passed; delay 0 answers at once
  assign mem_ack = mem_req && (cnt >= delay);
  // outside an ack the bus shows the inverse of the last word, so stale data cannot match
  always_comb begin
    if (!mem_ack)
      mem_rdata = ~last;
    else if (mem_word)
      mem_rdata = {m[mem_addr], m[mem_addr + 16'h0001]};
    else
      mem_rdata = {8'h00, m[mem_addr]};
  end
  // plain always so the bench may preload the array directly
  always @(posedge sys_clk) begin
    cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
    if (mem_ack)
      last <= mem_rdata;
    if (mem_ack && mem_we && mem_word) begin
      m[mem_addr]           <= mem_wdata[15:8];
      m[mem_addr + 16'h0001] <= mem_wdata[7:0];
    end else if (mem_ack && mem_we) begin
      m[mem_addr] <= mem_wdata[7:0];
    end
  end
endmodule

// ===== verif/cpu_branch_sysctl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module cpu_branch_sysctl_tb;
  import cpu_ctl_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        insn_valid = 1'b0;
  logic        wake = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  delay = 4'h0;
  insn_s       insn = '0;
  block_s      blk_in = '0;
  logic        insn_ready, done, sleeping, mem_req, mem_we, mem_word, mem_ack;
  logic [15:0] pc, mem_addr, mem_wdata, mem_rdata;
  logic [7:0]  condition_code_register;
  result_s     res;
  block_s      blk;
  int          mismatches = 0;
  int          n_checks = 0;
  // 20 MHz system clock
  always #25 sys_clk = ~sys_clk;
  cpu_branch_sysctl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .insn_valid(insn_valid), .insn_ready(insn_ready), .insn(insn), .blk_in(blk_in),
    .wake(wake), .res(res), .blk(blk), .pc(pc), .condition_code_register(condition_code_register), .done(done),
    .sleeping(sleeping), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  mem_model mem (.sys_clk(sys_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .delay(delay),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // builds one decoded instruction with the unused fields cleared
  function automatic insn_s mk(op_e o, mode_e m, logic w, logic [15:0] r, logic [7:0] b,
                               logic [15:0] e);
    insn_s i;
    i = '0;
    i.op = o;
    i.mode = m;
    i.word = w;
    i.reg_val = r;
    i.byte2 = b;
    i.ext = e;
    return i;
  endfunction
  // branch condition table indexed by condition code, flags ordered n z v c
  function automatic logic holds(logic [3:0] c, logic [3:0] f);
    logic n, z, v, k;
    logic [15:0] t;
    {n, z, v, k} = f;
    t = {z | (n ^ v), ~(z | (n ^ v)), n ^ v, ~(n ^ v), n, ~n, v, ~v, z, ~z, k, ~k,
         k | z, ~(k | z), 1'b0, 1'b1};
    return t[c];
  endfunction
  // offers one instruction after the sequencer shows idle
  task automatic issue(input insn_s i);
    int n;
    n = 0;
    while (insn_ready !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      #1 n++;
    end
    insn = i;
    insn_valid = 1'b1;
    @(posedge sys_clk);
    #1 insn_valid = 1'b0;
  endtask
  // bounded wait for the completion pulse
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 200) `CHK("done", 1'b1, 1'b0)
  endtask
  task automatic run(input insn_s i);
    issue(i);
    wait_done();
  endtask
  // every condition against every flag pattern, odd negative displacement
  task automatic t_cond();
    insn_s i;
    logic [15:0] p, e;
    for (int f = 0; f < 16; f++) begin
      run(mk(load_condition_codes, am_imm8, 1'b0, 16'h0, f[7:0], 16'h0));
      `CHK("ccr", f[7:0], condition_code_register)
      for (int c = 0; c < 16; c++) begin
        i = mk(cond_branch, am_pcrel, 1'b0, 16'h0, 8'h83, 16'h0);
        i.cond = cond_e'(c);
        p = pc;
        run(i);
        e = holds(c[3:0], f[3:0]) ? ((p + 16'hff85) & 16'hfffe) : p + PC_STEP;
        `CHK("pc", e, pc)
        `CHK("ccr", f[7:0], condition_code_register)
      end
    end
  endtask
  // condition code moves and logic, then a no-operation
  task automatic t_ccr();
    logic [15:0] p;
    run(mk(load_condition_codes, am_imm8, 1'b0, 16'h0, 8'h5a, 16'h0));
    run(mk(and_condition_codes, am_imm8, 1'b0, 16'h0, 8'h0f, 16'h0));
    `CHK("ccr", 8'h0a, condition_code_register)
    run(mk(or_condition_codes, am_imm8, 1'b0, 16'h0, 8'h81, 16'h0));
    `CHK("ccr", 8'h8b, condition_code_register)
    run(mk(xor_condition_codes, am_imm8, 1'b0, 16'h0, 8'hff, 16'h0));
    `CHK("ccr", 8'h74, condition_code_register)
    run(mk(store_condition_codes, am_reg, 1'b0, 16'h0, 8'h0, 16'h0));
    `CHK("stc", 8'h74, res.reg_val[7:0])
    `CHK("reg_wr", 1'b1, res.reg_wr)
    run(mk(load_condition_codes, am_reg, 1'b0, 16'h0033, 8'h0, 16'h0));
    `CHK("ccr", 8'h33, condition_code_register)
    p = pc;
    run(mk(no_operation, am_reg, 1'b0, 16'h0, 8'h0, 16'h0));
    `CHK("pc", p + 16'h0002, pc)
    `CHK("ccr", 8'h33, condition_code_register)
    // a frozen clock enable must hold off even a waiting no-operation
    p = pc;
    clk_en = 1'b0;
    insn = mk(no_operation, am_reg, 1'b0, 16'h0, 8'h0, 16'h0);
    insn_valid = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 `CHK("pc_frozen", p, pc)
    clk_en = 1'b1;
    @(posedge sys_clk);
    #1 insn_valid = 1'b0;
    `CHK("pc", p + 16'h0002, pc)
    `CHK("done", 1'b1, done)
  endtask
  // jumps, calls and returns through a slow memory
  task automatic t_flow();
    insn_s i;
    logic [15:0] p;
    delay = 4'h3;
    run(mk(unconditional_jump, am_abs16, 1'b0, 16'h0, 8'h0, 16'h3457));
    `CHK("pc", 16'h3456, pc)
    mem.m[16'h0010] = 8'h12;
    mem.m[16'h0011] = 8'h35;
    run(mk(unconditional_jump, am_memind, 1'b0, 16'h0, 8'h10, 16'h0));
    `CHK("pc", 16'h1234, pc)
    i = mk(absolute_subroutine_call, am_abs16, 1'b0, 16'h0, 8'h0, 16'h4000);
    i.len4 = 1'b1;
    i.sp = 16'h0f00;
    p = pc;
    run(i);
    `CHK("pc", 16'h4000, pc)
    `CHK("sp", 16'h0efe, res.sp)
    `CHK("stack", p + 16'h0004, {mem.m[16'h0efe], mem.m[16'h0eff]})
    i = mk(subroutine_return, am_reg, 1'b0, 16'h0, 8'h0, 16'h0);
    i.sp = 16'h0efe;
    run(i);
    `CHK("pc", p + 16'h0004, pc)
    `CHK("sp", 16'h0f00, res.sp)
    i = mk(relative_subroutine_call, am_pcrel, 1'b0, 16'h0, 8'h10, 16'h0);
    i.sp = 16'h0f00;
    p = pc;
    run(i);
    `CHK("pc", p + 16'h0012, pc)
    `CHK("stack", p + 16'h0002, {mem.m[16'h0efe], mem.m[16'h0eff]})
    mem.m[16'h0e00] = 8'h2c;
    mem.m[16'h0e02] = 8'h56;
    mem.m[16'h0e03] = 8'h78;
    i = mk(exception_return, am_reg, 1'b0, 16'h0, 8'h0, 16'h0);
    i.sp = 16'h0e00;
    run(i);
    `CHK("ccr", 8'h2c, condition_code_register)
    `CHK("pc", 16'h5678, pc)
    `CHK("sp", 16'h0e04, res.sp)
  endtask
  // power-down holds until wake
  task automatic t_sleep();
    logic [15:0] p;
    p = pc;
    issue(mk(power_down, am_reg, 1'b0, 16'h0, 8'h0, 16'h0));
    repeat (4) @(posedge sys_clk);
    #1 `CHK("sleeping", 1'b1, sleeping)
    `CHK("done", 1'b0, done)
    wake = 1'b1;
    wait_done();
    wake = 1'b0;
    `CHK("pc", p + 16'h0002, pc)
  endtask
  // block copy of three bytes, then a zero count that must touch nothing
  task automatic t_block();
    logic [15:0] p;
    for (int k = 0; k < 3; k++) mem.m[16'h0100 + k] = 8'ha1 + k[7:0];
    mem.m[16'h0400] = 8'hee;
    delay = 4'h2;
    blk_in = {8'h03, 16'h0100, 16'h0200};
    p = pc;
    run(mk(block_copy, am_reg, 1'b0, 16'h0, 8'h0, 16'h0));
    for (int k = 0; k < 3; k++) `CHK("copy", 8'ha1 + k[7:0], mem.m[16'h0200 + k])
    `CHK("blk", {8'h00, 16'h0103, 16'h0203}, blk)
    `CHK("pc", p + PC_STEP, pc)
    blk_in = {8'h00, 16'h0100, 16'h0400};
    run(mk(block_copy, am_reg, 1'b0, 16'h0, 8'h0, 16'h0));
    `CHK("zero", 8'hee, mem.m[16'h0400])
    delay = 4'h0;
  endtask
  // one address or operand result: sel 0 ea, 1 register, 2 operand, else bit number
  task automatic gen(input op_e o, input mode_e m, input logic w, input logic [15:0] r,
                     input int sel, input logic [15:0] e);
    run(mk(o, m, w, r, 8'h57, 16'h0102));
    case (sel)
      0: `CHK("ea", e, res.ea)
      1: `CHK("reg_val", e, res.reg_val)
      2: `CHK("operand", e, res.operand)
      default: `CHK("bit_num", e[2:0], res.bit_num)
    endcase
  endtask
  task automatic t_addr();
    gen(address_gen, am_reg, 1'b1, 16'h1235, 2, 16'h1235);
    gen(address_gen, am_ind, 1'b0, 16'h1235, 0, 16'h1235);
    gen(address_gen, am_disp, 1'b1, 16'h1235, 0, 16'h1336);
    gen(address_gen, am_postinc, 1'b1, 16'h1234, 0, 16'h1234);
    gen(address_gen, am_postinc, 1'b1, 16'h1234, 1, 16'h1236);
    gen(address_gen, am_postinc, 1'b0, 16'h1235, 1, 16'h1236);
    gen(address_gen, am_predec, 1'b0, 16'h1234, 0, 16'h1233);
    gen(address_gen, am_predec, 1'b1, 16'h1234, 1, 16'h1232);
    gen(address_gen, am_abs8, 1'b0, 16'h1234, 0, 16'hff57);
    gen(address_gen, am_abs16, 1'b0, 16'h1234, 0, 16'h0102);
    gen(address_gen, am_imm8, 1'b0, 16'h1234, 2, 16'h0057);
    gen(address_gen, am_imm16, 1'b1, 16'h1234, 2, 16'h0102);
    gen(address_gen, am_abs8, 1'b0, 16'h1234, 3, 16'h0005);
    gen(subtract_small_constant, am_reg, 1'b1, 16'h1234, 1, 16'h1232);
    gen(add_small_constant, am_reg, 1'b0, 16'h1234, 1, 16'h1235);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the whole run needs a few hundred cycles
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    `CHK("pc", PC_RESET, pc)
    `CHK("ccr", CCR_RESET, condition_code_register)
    t_cond();
    t_ccr();
    t_flow();
    t_sleep();
    t_block();
    t_addr();
    end_of_test();
  end
endmodule
